// ### rtl/rsp_indicator.sv
// Top: signal-strength PWM indicator with hold timer
//
// What this block does
// RULE1: PWM appears on the pin only while its setting equals one.
// RULE2: Each packet received while the setting equals one recomputes duty from margin and restarts the hold timer.
// RULE3: When the hold timer expires, PWM stops and the pin stays low.
// RULE4: Hold timer counts 100 ms steps, default 40 steps.
// RULE5: Margin bands 30, 20, 10 dB map to 79.39, 62.42, 45.45 % duty.
// RULE6: Free-running counter PWM, threshold loaded at period boundary.
`timescale 1ns/1ps
module rsp_indicator
   import rsp_pkg::*;
#(
   parameter int unsigned STEP_CYC = HOLD_STEP_CYC
)
(
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic [1:0] strength_pin_config,
   input  wire logic [7:0] strength_hold_timer,
   input  wire rsp_rx_t    rx,
   output logic            io_line_ten,
   output logic            showing
);

   initial
   begin
      if (STEP_CYC < 1 || STEP_CYC > 16777215)
         $error("rsp_indicator: STEP_CYC out of range");
   end

   // ----------------------------------------------------------------
   // Margin to duty mapping
   // ----------------------------------------------------------------
   // Linear within each band, saturating at the top band
   function automatic logic [7:0] rsp_duty(input logic [7:0] m);
      logic [15:0] part;
      part = '0;
      if (m >= MARGIN_30DB)
         rsp_duty = DUTY_3LED + 8'((16'(m - MARGIN_30DB) * 16'(DUTY_SPAN)
                    / 16'(MARGIN_BAND)) > 16'h0033 ? 16'h0033
                    : (16'(m - MARGIN_30DB) * 16'(DUTY_SPAN)
                    / 16'(MARGIN_BAND)));
      else if (m >= MARGIN_20DB)
      begin
         part = 16'(m - MARGIN_20DB) * 16'(DUTY_SPAN) / 16'(MARGIN_BAND);
         rsp_duty = DUTY_2LED + part[7:0];
      end
      else if (m >= MARGIN_10DB)
      begin
         part = 16'(m - MARGIN_10DB) * 16'(DUTY_SPAN) / 16'(MARGIN_BAND);
         rsp_duty = DUTY_1LED + part[7:0];
      end
      else
      begin
         part = 16'(m) * 16'(DUTY_SPAN) / 16'(MARGIN_BAND);
         rsp_duty = DUTY_1LED - DUTY_SPAN + part[7:0];
      end
   endfunction : rsp_duty

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   wire enabled = (strength_pin_config == PIN_CFG_PWM);     // RULE1
   wire pkt     = rx.valid && enabled;

   rsp_state_t  state_q;
   rsp_state_t  state_d;
   logic [7:0]  duty_q;
   logic [7:0]  steps_q;
   logic [23:0] tick_q;
   wire         tick    = (tick_q == 24'(STEP_CYC - 1));
   wire         expired = (state_q == RSP_SHOW) && tick
                          && (steps_q <= 8'h01);

   // Next state: packet wins over expiry in the same cycle
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         RSP_IDLE:
            if (pkt && strength_hold_timer != 8'h00)
               state_d = RSP_SHOW;
         RSP_SHOW:
            if (!enabled)
               state_d = RSP_IDLE;
            else if (pkt)
               state_d = (strength_hold_timer != 8'h00) ? RSP_SHOW
                                                         : RSP_IDLE;
            else if (expired)
               state_d = RSP_IDLE;                    // RULE3
         default:
            state_d = RSP_IDLE;
      endcase
   end

   // ----------------------------------------------------------------
   // State and duty
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_q <= RSP_IDLE;
         duty_q  <= '0;
      end
      else
      begin
         state_q <= state_d;
         if (pkt)
            duty_q <= rsp_duty(rx.margin);          // RULE2 RULE5
      end
   end

   // ----------------------------------------------------------------
   // Hold timer: 100 ms tick prescaler and step counter
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         tick_q  <= '0;
         steps_q <= HOLD_STEPS_RST;                  // RULE4
      end
      else if (pkt)
      begin
         tick_q  <= '0;                              // RULE2
         steps_q <= strength_hold_timer;             // RULE2
      end
      else if (state_q == RSP_SHOW)
      begin
         tick_q <= tick ? '0 : tick_q + 24'h000001;   // RULE4
         if (tick && steps_q != 8'h00)
            steps_q <= steps_q - 8'h01;
      end
      else
         tick_q <= '0;
   end

   // ----------------------------------------------------------------
   // PWM generator
   // ----------------------------------------------------------------
   logic pwm_raw;

   rsp_pwm_core #(
      .W    (PWM_W)
   ) u_pwm (
      .mclk (mclk),
      .nrst (nrst),
      .run  (state_q == RSP_SHOW),
      .duty (duty_q),
      .pwm  (pwm_raw)
   );

   // Pin low whenever disabled or timer expired
   assign io_line_ten = pwm_raw && enabled;          // RULE1 RULE3
   assign showing     = (state_q == RSP_SHOW);

endmodule : rsp_indicator

// ### rtl/rsp_pkg.sv
// Package: constants and types for the signal-strength PWM indicator
package rsp_pkg;

   // ----------------------------------------------------------------
   // Clock and timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ          = 25_000_000;
   localparam int unsigned HOLD_STEP_MS    = 100;
   localparam int unsigned HOLD_STEP_CYC   = CLK_HZ / 1000 * HOLD_STEP_MS;
   localparam logic [7:0]  HOLD_STEPS_RST  = 8'h28;   // 40 steps, 4 s
   localparam logic [1:0]  PIN_CFG_PWM     = 2'h1;    // Setting 1 = PWM

   // ----------------------------------------------------------------
   // PWM period and duty thresholds (in counts of a 256 period)
   // ----------------------------------------------------------------
   localparam int unsigned PWM_W           = 8;
   // 79.39 %, 62.42 %, 45.45 % of 256, rounded up
   localparam logic [7:0]  DUTY_3LED       = 8'hcc;
   localparam logic [7:0]  DUTY_2LED       = 8'ha0;
   localparam logic [7:0]  DUTY_1LED       = 8'h75;
   localparam logic [7:0]  DUTY_SPAN       = 8'h2b;   // Band width
   localparam logic [7:0]  MARGIN_10DB     = 8'h0a;
   localparam logic [7:0]  MARGIN_20DB     = 8'h14;
   localparam logic [7:0]  MARGIN_30DB     = 8'h1e;
   localparam logic [7:0]  MARGIN_BAND     = 8'h0a;

   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       valid;    // One-cycle pulse per packet
      logic [7:0] margin;   // Link margin in dB
   } rsp_rx_t;

   typedef enum logic [1:0] {
      RSP_IDLE = 2'b00,
      RSP_SHOW = 2'b01
   } rsp_state_t;

endpackage : rsp_pkg

// ### rtl/rsp_pwm_core.sv
// PWM core: free-running counter with period-aligned compare load
`timescale 1ns/1ps
module rsp_pwm_core
   import rsp_pkg::*;
#(
   parameter int unsigned W = PWM_W
)
(
   input  wire logic         mclk,
   input  wire logic         nrst,
   input  wire logic         run,
   input  wire logic [W-1:0] duty,
   output logic              pwm
);

   initial
   begin
      if (W < 2 || W > 16)
         $error("rsp_pwm_core: W out of range");
   end

   logic [W-1:0] cnt_q;
   logic [W-1:0] cmp_q;
   logic         pwm_q;
   wire          wrap = (cnt_q == {W{1'b1}});

   // ----------------------------------------------------------------
   // Counter, threshold and output
   // ----------------------------------------------------------------
   // Threshold changes only at wrap, so duty updates cause no runt pulses; run changing mid-period still cuts a pulse
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_q <= '0;
         cmp_q <= '0;
         pwm_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_q + 1'b1;                  // RULE6
         if (wrap)
            cmp_q <= duty;                       // RULE6
         pwm_q <= run && (cnt_q < cmp_q);
      end
   end

   assign pwm = pwm_q;

endmodule : rsp_pwm_core

// ### sim/rsp_indicator_sva.sv
// Checker: timing relations at the indicator ports
`timescale 1ns/1ps
module rsp_indicator_sva
   import rsp_pkg::*;
#(
   parameter int unsigned STEP_CYC = HOLD_STEP_CYC
)
(
   input wire logic       mclk,
   input wire logic       nrst,
   input wire logic [1:0] strength_pin_config,
   input wire logic [7:0] strength_hold_timer,
   input wire rsp_rx_t    rx,
   input wire logic       io_line_ten,
   input wire logic       showing
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   logic [31:0] age_q;
   logic [8:0]  gap_q;
   wire         on_w  = strength_pin_config == PIN_CFG_PWM;
   wire  [31:0] lim_w = strength_hold_timer * STEP_CYC;
   // Age of last packet, spacing of pin rises
   always_ff @(posedge mclk or negedge nrst)
      if (!nrst)
      begin
         age_q <= '0;
         gap_q <= 9'h1ff;
      end
      else
      begin
         age_q <= (on_w && rx.valid) ? '0 : age_q + 1;
         gap_q <= $rose(io_line_ten) ? 9'h001 : gap_q + {8'h00, ~&gap_q};
      end
   off_cfg_a: assert property (!on_w [*2] |-> !io_line_ten)
      else $error("pin active while disabled");
   pkt_show_a: assert property (on_w && rx.valid && strength_hold_timer != 0
      |=> showing) else $error("packet not shown");
   no_early_a: assert property (showing && on_w && age_q + 3 < lim_w ##1 on_w
      |-> showing) else $error("show ended early");
   idle_low_a: assert property (!showing [*2] |-> !io_line_ten)
      else $error("pin high while idle");
   hold_len_a: assert property ($fell(showing) && on_w && $past(on_w)
      |-> age_q + 2 >= lim_w && age_q <= lim_w)
      else $error("hold length wrong");
   pwm_per_a: assert property ($rose(io_line_ten) |-> gap_q >= 9'h0ff)
      else $error("pwm period too short");
   c_pkt: cover property (on_w && rx.valid);
   c_end: cover property ($fell(showing));
   c_pin: cover property ($rose(io_line_ten));
endmodule : rsp_indicator_sva
bind rsp_indicator rsp_indicator_sva #(.STEP_CYC(STEP_CYC)) i_sva (
   .mclk(mclk), .nrst(nrst), .strength_pin_config(strength_pin_config),
   .strength_hold_timer(strength_hold_timer), .rx(rx),
   .io_line_ten(io_line_ten), .showing(showing));

// ### sim/rsp_radio_model.sv
// Partner: receive path reporting each packet and its margin
`timescale 1ns/1ps
module rsp_radio_model
   import rsp_pkg::*;
(
   input wire logic mclk,
   output rsp_rx_t  rx
);
   initial rx = '{valid: 1'b0, margin: 8'h5a};
   // One-cycle report, stale margin inverted
   task automatic send(input logic [7:0] m);
      @(posedge mclk);
      #1 rx = '{valid: 1'b1, margin: m};
      @(posedge mclk);
      #1 rx = '{valid: 1'b0, margin: ~m};
   endtask : send
endmodule : rsp_radio_model

// ### sim/tb.sv
// Testbench: signal-strength indicator scenarios
`timescale 1ns/1ps
module tb;
   import rsp_pkg::*;
   localparam int LIM = 40 * 100;
   logic       mclk = 1'b0;
   logic       nrst = 1'b0;
   logic [1:0] cfg  = PIN_CFG_PWM;
   logic [7:0] hold = HOLD_STEPS_RST;
   rsp_rx_t    rx;
   logic       pin, showing;
   int         fails = 0, n_compared = 0, cyc = 0;
   logic [1:0] cfg_list[3] = '{2'h0, 2'h2, 2'h3};
   always #20 mclk = ~mclk;
   rsp_radio_model i_radio (.mclk(mclk), .rx(rx));
   rsp_indicator #(.STEP_CYC(100)) i_dut (.mclk(mclk), .nrst(nrst),
      .strength_pin_config(cfg), .strength_hold_timer(hold), .rx(rx),
      .io_line_ten(pin), .showing(showing));
   task automatic chk(input logic ok, input int got, input int exp);
      n_compared++;
      if (!ok)
      begin
         fails++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   // Sum of cycles with pin high and cycles with flag high
   task automatic busy(input int len, output int n);
      n = 0;
      repeat (len)
      begin
         tick(1);
         n += (pin !== 1'b0) + (showing !== 1'b0);
      end
   endtask : busy
   task automatic s_disabled();
      int n;
      foreach (cfg_list[i])
      begin
         cfg = cfg_list[i];
         i_radio.send(8'h23);
         busy(200, n);
         chk(n == 0, n, 0);
      end
      cfg = PIN_CFG_PWM;
   endtask : s_disabled
   task automatic s_bands();
      logic [7:0] mg[4] = '{8'h23, 8'h19, 8'h0f, 8'h05};
      int lo[4] = '{'hcc, 'ha0, 'h75, 0};
      int hi[4] = '{256, 'hcc, 'ha0, 'h74};
      int n;
      foreach (mg[i])
      begin
         i_radio.send(mg[i]);
         tick(700);
         busy(256, n);
         n -= 256;
         chk(n >= lo[i] && n <= hi[i], n, lo[i]);
      end
   endtask : s_bands
   task automatic s_restart();
      i_radio.send(8'h19);
      tick(LIM - 1000);
      i_radio.send(8'h19);
      tick(LIM - 1000);
      chk(showing === 1'b1, showing, 1);
   endtask : s_restart
   task automatic s_expiry();
      int n = 0;
      i_radio.send(8'h14);
      while (showing === 1'b1 && n < LIM + 50)
      begin
         tick(1);
         n++;
      end
      chk(n >= LIM - 3 && n <= LIM + 2, n, LIM);
      busy(300, n);
      chk(n == 0, n, 0);
   endtask : s_expiry
   task automatic tally_and_finish();
      if (fails == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : tally_and_finish
   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         fails++;
         tally_and_finish();
      end
   end
   initial
   begin
      tick(16);
      nrst = 1'b1;
      s_disabled();
      s_bands();
      s_restart();
      s_expiry();
      tally_and_finish();
   end
endmodule : tb
